// File: bench/fspa_flash_model.sv
`default_nettype none
module fspa_flash_model #(
   parameter logic [7:0] MFR_ID = 8'h3c, // arbitrary value
   parameter logic [7:0] DEV_ID = 8'ha6 // arbitrary value
) (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [20:0] addr,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   timeunit 1ns;
   timeprecision 1ns;
   import fspa_pkg::*;
   // no program or erase runs here, so abort is always ignored
   logic [7:0] st = 8'h80;
   logic [47:0] h = '0;
   logic [1:0] prot = 2'h0;
   logic idm = 1'b0;
   logic [20:0] la = '0;
   logic wv = 1'b0;
   logic [7:0] lv = 8'h00;
   // select and strobe move on one host edge, so qualify inside the pulse
   always @(negedge we_n) begin
      #1;
      wv = !ce_n && oe_n;
      if (wv) la = addr;
   end
   always @(posedge we_n) begin
      if (wv) begin
         h = {h[39:0], din};
         if (h[47:8] == {CMD_UNLOCK1, CMD_UNLOCK2, CMD_SETUP, CMD_UNLOCK1, CMD_UNLOCK2}
             && (din == CMD_LOCK || din == CMD_UNPROT)) begin
            // only the two end sectors can be protected
            if (la[20:16] == 5'h00 || la[20:16] == 5'h1f) prot[la[20]] = din == CMD_LOCK;
            idm = 1'b0;
            st[7] = 1'b0;
            st[7] <= #700 1'b1;
         end else if (h[23:8] == {CMD_UNLOCK1, CMD_UNLOCK2} && din == CMD_ID_READ) idm = 1'b1;
         else if (din == CMD_READ_ARRAY) idm = 1'b0;
         else if (din == CMD_CLEAR_STATUS) st[5:4] = 2'h0;
      end
   end
   // released bus shows the inverse, never a stale value
   always @(ce_n, oe_n, addr, st, prot, idm) begin
      if (!ce_n && !oe_n) begin
         if (idm) lv = addr[1:0] == 2'h0 ? MFR_ID :
                       addr[1:0] == 2'h1 ? DEV_ID : {6'h0, prot};
         else lv = {st[7:4], |prot, 3'h5};
         dout = lv;
      end else dout = ~lv;
   end
endmodule : fspa_flash_model
`default_nettype wire

// File: bench/fspa_host_checker.sv
`default_nettype none
module fspa_host_checker
   import fspa_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] op_code,
   input wire logic op_busy,
   input wire logic op_done,
   input wire logic [7:0] op_status,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   input wire logic [20:0] flash_addr,
   input wire logic [7:0] flash_dq_o,
   input wire logic flash_dq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr;
      $fell(flash_we_n);
   endsequence
   sequence s_wr_hold;
      !flash_we_n && $stable(flash_addr) && $stable(flash_dq_o) ##1 flash_we_n;
   endsequence
   property p_rst_idle;
      $fell(sys_rst) |-> flash_ce_n && flash_we_n && flash_oe_n && op_status == 8'h80;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_wr_gate;
      !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe;
   endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("bad write controls");
   property p_rd_gate;
      !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe;
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("bad read controls");
   property p_wr_shape;
      s_wr |=> s_wr_hold;
   endproperty
   a_wr_shape: assert property (p_wr_shape) else $error("write pulse wrong");
   property p_mask;
      op_done |-> op_status[2:0] == 3'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("reserved bits kept");
   property p_done;
      op_done |=> !op_done && !op_busy;
   endproperty
   a_done: assert property (p_done) else $error("done not a pulse");
   property p_first;
      // strobe drops one cycle after busy rises
      ($rose(op_busy) && ($past(op_code) <= OP_ABORT)) |=> s_wr
         ##0 (flash_dq_o == CMD_UNLOCK1 && flash_addr == ADDR_UNLOCK1);
   endproperty
   a_first: assert property (p_first) else $error("first write wrong");
   property p_setup;
      s_wr ##0 flash_dq_o == CMD_SETUP |-> $past(flash_dq_o, 3) == CMD_UNLOCK2;
   endproperty
   a_setup: assert property (p_setup) else $error("setup order wrong");
   property p_final;
      s_wr ##0 (flash_dq_o == CMD_LOCK || flash_dq_o == CMD_UNPROT)
         |-> $past(flash_dq_o, 9) == CMD_SETUP && flash_addr[15:0] == 16'h0;
   endproperty
   a_final: assert property (p_final) else $error("final write wrong");
endmodule : fspa_host_checker
`default_nettype wire

// File: bench/tb_fspa_host.sv
`default_nettype none
module tb_fspa_host;
   timeunit 1ns;
   timeprecision 1ns;
   import fspa_pkg::*;
   localparam logic [7:0] MFR_ID = 8'h3c; // arbitrary value
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   logic [2:0] op_code = 3'h0;
   logic [4:0] op_sector = 5'h00;
   logic op_busy, op_done, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
   logic [7:0] op_status, op_id_data, flash_dq_o, flash_dq_i;
   logic [20:0] flash_addr;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   fspa_host u_fspa_host (.core_clk, .sys_rst, .op_valid, .op_code, .op_sector, .op_busy,
      .op_done, .op_status, .op_id_data, .flash_ce_n, .flash_we_n, .flash_oe_n,
      .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i);
   fspa_flash_model #(.MFR_ID(MFR_ID)) u_fspa_flash_model (.ce_n(flash_ce_n),
      .we_n(flash_we_n), .oe_n(flash_oe_n), .addr(flash_addr), .din(flash_dq_o),
      .dout(flash_dq_i));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("checks=%0d errors=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   // whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic run_op(input logic [2:0] code, input logic [4:0] sec);
      int n;
      @(posedge core_clk);
      #2;
      op_valid = 1'b1;
      op_code = code;
      op_sector = sec;
      @(posedge core_clk);
      #2;
      op_valid = 1'b0;
      n = 0;
      while (op_done !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         #2;
         n++;
      end
      if (n == 2000) error_cnt++;
   endtask : run_op
   task automatic prot_op(input logic [2:0] code, input logic [4:0] sec,
         input logic [7:0] st_exp, input logic [7:0] id_exp);
      run_op(code, sec);
      chk(op_status, st_exp);
      run_op(OP_VERIFY, sec);
      chk(op_id_data, id_exp);
      run_op(OP_CLEAR, sec);
   endtask : prot_op
   task automatic t_reset();
      chk(op_status, 8'h80);
      chk(op_id_data, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_lock();
      prot_op(OP_LOCK, 5'h05, 8'h80, 8'h00);
      prot_op(OP_LOCK, 5'h00, 8'h88, 8'h01);
      prot_op(OP_LOCK, 5'h1f, 8'h88, 8'h03);
      $display("lock test done");
   endtask : t_lock
   task automatic t_unprot();
      prot_op(OP_UNPROT, 5'h00, 8'h88, 8'h02);
      prot_op(OP_UNPROT, 5'h1f, 8'h80, 8'h00);
      $display("unprotect test done");
   endtask : t_unprot
   task automatic t_abort_idle();
      run_op(OP_ABORT, 5'h00);
      chk(op_status, 8'h80);
      run_op(OP_CLEAR, 5'h00);
      run_op(OP_POLL, 5'h00);
      chk(op_status, 8'h80);
      $display("abort test done");
   endtask : t_abort_idle
   task automatic t_id();
      run_op(OP_ID, 5'h00);
      chk(op_id_data, MFR_ID);
      run_op(OP_CLEAR, 5'h00);
      run_op(OP_POLL, 5'h00);
      chk(op_status, 8'h80);
      $display("id test done");
   endtask : t_id
   initial begin
      repeat (12) @(posedge core_clk);
      #2;
      sys_rst = 1'b0;
      @(posedge core_clk);
      #2;
      t_reset();
      t_lock();
      t_unprot();
      t_abort_idle();
      t_id();
      complete_run();
   end
endmodule : tb_fspa_host
bind fspa_host fspa_host_checker u_fspa_host_checker (.core_clk, .sys_rst, .op_code,
   .op_busy, .op_done, .op_status, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr,
   .flash_dq_o, .flash_dq_oe);
`default_nettype wire

// File: rtl/fspa_host.sv
// Summary of operation
// - mask reserved low status bits
// - lock is six writes ending in lock code
// - third write carries shared setup code
// - leave id mode with read/reset write
// - unprotect is five writes plus unprotect code
// - after abort write read-array then clear status
`default_nettype none
module fspa_host
   import fspa_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire logic [2:0] op_code,
   input wire logic [4:0] op_sector,
   output logic op_busy,
   output logic op_done,
   output logic [7:0] op_status,
   output logic [7:0] op_id_data,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [20:0] flash_addr,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_i
);
   import fspa_pkg::*;

   localparam int NSEQ = 6;
   fspa_state_t st_q, st_d;
   logic [2:0] idx_q, idx_d, len_q, len_d, op_q, op_d;
   logic [3:0] cnt_q, cnt_d;
   logic [4:0] sec_q, sec_d;
   logic [7:0] dq_s1_q, dq_s2_q;
   logic ce_q, ce_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
   logic [20:0] addr_q, addr_d;
   logic [7:0] dout_q, dout_d, stat_q, stat_d, id_q, id_d;
   logic busy_q, busy_d, done_q, done_d;
   logic [20:0] seq_addr [NSEQ];
   logic [7:0] seq_data [NSEQ];
   logic [20:0] sec_base;

   assign sec_base = {sec_q, 16'h0000};

   // write sequence table; one entry per bus cycle
   always_comb begin
      for (int i = 0; i < NSEQ; i++) begin
         seq_addr[i] = ADDR_UNLOCK1;
         seq_data[i] = CMD_READ_ARRAY;
      end
      unique case (op_q)
         OP_LOCK, OP_UNPROT: begin
            seq_addr[0] = ADDR_UNLOCK1; seq_data[0] = CMD_UNLOCK1;
            seq_addr[1] = ADDR_UNLOCK2; seq_data[1] = CMD_UNLOCK2;
            seq_addr[2] = ADDR_UNLOCK1; seq_data[2] = CMD_SETUP;
            seq_addr[3] = ADDR_UNLOCK1; seq_data[3] = CMD_UNLOCK1;
            seq_addr[4] = ADDR_UNLOCK2; seq_data[4] = CMD_UNLOCK2;
            seq_addr[5] = sec_base;
            seq_data[5] = (op_q == OP_LOCK) ? CMD_LOCK : CMD_UNPROT;
         end
         OP_ABORT, OP_ID, OP_VERIFY: begin
            seq_addr[0] = ADDR_UNLOCK1; seq_data[0] = CMD_UNLOCK1;
            seq_addr[1] = ADDR_UNLOCK2; seq_data[1] = CMD_UNLOCK2;
            seq_addr[2] = ADDR_UNLOCK1;
            seq_data[2] = (op_q == OP_ABORT) ? CMD_ABORT : CMD_ID_READ;
         end
         OP_CLEAR: begin
            // read-array first, then clear status before further work
            seq_data[0] = CMD_READ_ARRAY;
            seq_data[1] = CMD_CLEAR_STATUS;
         end
         default: begin
            seq_data[0] = CMD_READ_ARRAY;
         end
      endcase
   end

   function automatic logic [2:0] seq_len(input logic [2:0] op);
      unique case (op)
         OP_LOCK, OP_UNPROT: seq_len = 3'h6;
         // protection read needs the full id entry, a bare command is ignored
         OP_ABORT, OP_ID, OP_VERIFY: seq_len = 3'h3;
         OP_CLEAR: seq_len = 3'h2;
         default: seq_len = 3'h0;
      endcase
   endfunction : seq_len

   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      len_d = len_q;
      op_d = op_q;
      cnt_d = cnt_q;
      sec_d = sec_q;
      ce_d = ce_q;
      we_d = we_q;
      oe_d = oe_q;
      doe_d = doe_q;
      addr_d = addr_q;
      dout_d = dout_q;
      stat_d = stat_q;
      id_d = id_q;
      busy_d = busy_q;
      done_d = 1'b0;
      unique case (st_q)
         FSPA_IDLE: begin
            if (op_valid) begin
               op_d = op_code;
               sec_d = op_sector;
               len_d = seq_len(op_code);
               idx_d = 3'h0;
               busy_d = 1'b1;
               // sequences are issued whole; the user cannot cut one short
               st_d = (seq_len(op_code) == 3'h0) ? FSPA_RLOW : FSPA_WLOW;
               cnt_d = 4'h0;
            end
         end
         FSPA_WLOW: begin
            // gate high before select and strobe drop
            oe_d = 1'b1;
            ce_d = 1'b0;
            we_d = 1'b0;
            doe_d = 1'b1;
            addr_d = seq_addr[idx_q];
            dout_d = seq_data[idx_q];
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= WP_CYC) begin
               st_d = FSPA_WHIGH;
               cnt_d = 4'h0;
            end
         end
         FSPA_WHIGH: begin
            // command taken on the rising strobe edge
            we_d = 1'b1;
            ce_d = 1'b1;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= WPH_CYC) begin
               doe_d = 1'b0;
               cnt_d = 4'h0;
               if (idx_q + 3'h1 >= len_q) begin
                  st_d = (op_q == OP_CLEAR) ? FSPA_DONE : FSPA_RLOW;
               end else begin
                  idx_d = idx_q + 3'h1;
                  st_d = FSPA_WLOW;
               end
            end
         end
         FSPA_RLOW: begin
            // select and gate toggle per read so status is relatched
            ce_d = 1'b0;
            oe_d = 1'b0;
            doe_d = 1'b0;
            addr_d = (op_q == OP_ID) ? ADDR_ID_MFR :
                     (op_q == OP_VERIFY) ? ADDR_ID_PROT : sec_base;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= RD_CYC + 4'h2) begin
               st_d = FSPA_RDONE;
               cnt_d = 4'h0;
            end
         end
         FSPA_RDONE: begin
            ce_d = 1'b1;
            oe_d = 1'b1;
            if (op_q == OP_ID || op_q == OP_VERIFY) begin
               id_d = dq_s2_q;
               st_d = FSPA_DONE;
            end else begin
               // busy encodings carry no failure meaning; keep polling
               stat_d = dq_s2_q & STATUS_MASK;
               if (dq_s2_q[READY_BIT] || dq_s2_q[SUSPEND_BIT]) begin
                  st_d = FSPA_DONE;
               end else begin
                  st_d = FSPA_RLOW;
               end
            end
         end
         FSPA_DONE: begin
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d = FSPA_IDLE;
         end
         default: st_d = FSPA_IDLE;
      endcase
   end

   // device is in array read after power-up, so nothing is sent at reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= FSPA_IDLE;
         idx_q <= 3'h0;
         len_q <= 3'h0;
         op_q <= OP_POLL;
         cnt_q <= POLL_LIMIT_RST;
         sec_q <= 5'h00;
         ce_q <= 1'b1;
         we_q <= 1'b1;
         oe_q <= 1'b1;
         doe_q <= 1'b0;
         addr_q <= 21'h000000;
         dout_q <= 8'h00;
         stat_q <= 8'h80;
         id_q <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         len_q <= len_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         sec_q <= sec_d;
         ce_q <= ce_d;
         we_q <= we_d;
         oe_q <= oe_d;
         doe_q <= doe_d;
         addr_q <= addr_d;
         dout_q <= dout_d;
         stat_q <= stat_d;
         id_q <= id_d;
         busy_q <= busy_d;
         done_q <= done_d;
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // the part refuses work on locked end sectors; the user sees the fail flag
   assign op_busy = busy_q;
   assign op_done = done_q;
   assign op_status = stat_q;
   assign op_id_data = id_q;
   assign flash_ce_n = ce_q;
   assign flash_we_n = we_q;
   assign flash_oe_n = oe_q;
   assign flash_addr = addr_q;
   assign flash_dq_o = dout_q;
   assign flash_dq_oe = doe_q;
endmodule : fspa_host
`default_nettype wire

// File: shared/fspa_pkg.sv
`default_nettype none
package fspa_pkg;
   // status word bit positions
   localparam int unsigned READY_BIT = 7;
   localparam int unsigned SUSPEND_BIT = 6;
   localparam int unsigned ERASE_FAIL_BIT = 5;
   localparam int unsigned PROG_FAIL_BIT = 4;
   localparam int unsigned PROT_BIT = 3;
   // reserved low bits are masked off when polling
   localparam logic [7:0] STATUS_MASK = 8'hf8;
   // command codes
   localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_SETUP = 8'h80;
   localparam logic [7:0] CMD_LOCK = 8'h20;
   localparam logic [7:0] CMD_UNPROT = 8'h40;
   localparam logic [7:0] CMD_ABORT = 8'he0;
   localparam logic [7:0] CMD_ID_READ = 8'h90;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hf0;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [20:0] ADDR_UNLOCK1 = 21'h005555;
   localparam logic [20:0] ADDR_UNLOCK2 = 21'h002aaa;
   localparam logic [20:0] ADDR_ID_MFR = 21'h000000;
   localparam logic [20:0] ADDR_ID_DEV = 21'h000001;
   localparam logic [20:0] ADDR_ID_PROT = 21'h000002;
   // bus timing at 20 MHz
   localparam int unsigned CLK_NS = 50;
   localparam int unsigned TWP_NS = 60;
   localparam int unsigned TWPH_NS = 40;
   localparam int unsigned TSRA_NS = 120;
   localparam logic [3:0] WP_CYC = 4'((TWP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WPH_CYC = 4'((TWPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RD_CYC = 4'((TSRA_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] POLL_LIMIT_RST = 4'h0;
   // user operations
   localparam logic [2:0] OP_LOCK = 3'h0;
   localparam logic [2:0] OP_UNPROT = 3'h1;
   localparam logic [2:0] OP_ABORT = 3'h2;
   localparam logic [2:0] OP_ID = 3'h3;
   localparam logic [2:0] OP_CLEAR = 3'h4;
   localparam logic [2:0] OP_POLL = 3'h5;
   localparam logic [2:0] OP_VERIFY = 3'h6;
   typedef enum logic [2:0] {
      FSPA_IDLE, FSPA_WLOW, FSPA_WHIGH, FSPA_RLOW, FSPA_RDONE, FSPA_DONE
   } fspa_state_t;
endpackage : fspa_pkg
`default_nettype wire
